// ### rcw_ctrl.sv
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rcw_params.svh"

module rcw_ctrl #(
    parameter int HALF_SEC_CYC = `RCW_HALF_SEC_NS / `RCW_CLK_PERIOD_NS,
    parameter int HAZARD_CYC   = `RCW_HAZARD_CYC
) (
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        soft_rst_i,
    input  wire logic        ce_i,
    input  wire logic        wr_seq_active_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output var  logic [31:0] avs_readdata_o,
    output var  logic        avs_waitrequest_o,
    output var  logic        rtc_clk_out_o,
    output var  logic        rtc_clk_oe_n_o
);

    // ----------------------------------------------------------------
    // state and bus bundle
    // ----------------------------------------------------------------
    rcw_pkg::rcw_state_t   s_q;
    rcw_pkg::rcw_state_t   s_d;
    rcw_pkg::rcw_bus_req_t req;

    localparam logic [31:0] HALF_LAST  = 32'(HALF_SEC_CYC - 1);
    localparam logic [31:0] HAZ_START  = 32'(HALF_SEC_CYC - HAZARD_CYC - 1);

    logic        bus_req;
    logic        take_wr;
    logic        wr_ctrl;
    logic        wr_time;
    logic        sec_wr;
    logic        half_tick;
    logic        sec_tick;
    logic [31:0] time_word;
    logic [31:0] ctrl_word;
    logic [31:0] rd_val;
    logic [31:0] be_mask;
    logic [31:0] time_new;

    assign req.address    = avs_address_i;
    assign req.read       = avs_read_i;
    assign req.write      = avs_write_i;
    assign req.writedata  = avs_writedata_i;
    assign req.byteenable = avs_byteenable_i;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    assign bus_req = req.read | req.write;
    // a write lands only on the edge where waitrequest is seen low
    assign take_wr = req.write & ~s_q.waitreq;
    assign wr_ctrl = take_wr & (req.address == `RCW_OFS_CONTROL);
    assign wr_time = take_wr & (req.address == `RCW_OFS_TIME);
    // locked writes do not reach the seconds field, so they do not clear the flag
    assign sec_wr  = wr_time & s_q.unlock & req.byteenable[1];

    assign half_tick = s_q.on & (s_q.presc == HALF_LAST);
    assign sec_tick  = half_tick & s_q.half;

    assign time_word = {3'h0, s_q.tv.hour, 1'b0, s_q.tv.min, 1'b0, s_q.tv.sec, 8'h00};
    assign be_mask   = {{8{req.byteenable[3]}}, {8{req.byteenable[2]}},
                        {8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
    assign time_new  = ((time_word & ~be_mask) | (req.writedata & be_mask)) & `RCW_TIME_MASK;

    always_comb
    begin
        ctrl_word                  = `RCW_CONTROL_RST;
        ctrl_word[`RCW_BIT_ON]     = s_q.on;
        ctrl_word[`RCW_BIT_UNLOCK] = s_q.unlock;
        ctrl_word[`RCW_BIT_HAZARD] = s_q.hazard;
        ctrl_word[`RCW_BIT_HALF]   = s_q.half;
        ctrl_word[`RCW_BIT_OE]     = s_q.oe;
    end

    always_comb
    begin
        unique case (req.address)
            `RCW_OFS_CONTROL: rd_val = ctrl_word;
            `RCW_OFS_TIME:    rd_val = time_word;
            default:          rd_val = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;

        // bus slave: one wait cycle, then answer
        if (bus_req && s_q.waitreq)
        begin
            s_d.waitreq = 1'b0;
            s_d.rdata   = req.read ? rd_val : 32'h0000_0000;
        end
        else
        begin
            s_d.waitreq = 1'b1;
        end

        // timebase
        if (s_q.on)
        begin
            if (half_tick)
            begin
                s_d.presc = 32'h0000_0000;
                s_d.half  = ~s_q.half; // R6
            end
            else
            begin
                s_d.presc = s_q.presc + 32'h0000_0001;
            end
        end

        // carry ripple seconds -> minutes -> hours
        if (sec_tick)
        begin
            if (s_q.tv.sec >= `RCW_SEC_MAX)
            begin
                s_d.tv.sec = 7'h00;
                if (s_q.tv.min >= `RCW_MIN_MAX)
                begin
                    s_d.tv.min  = 7'h00;
                    s_d.tv.hour = (s_q.tv.hour >= `RCW_HOUR_MAX) ? 5'h00
                                                                 : s_q.tv.hour + 5'h01;
                end
                else
                begin
                    s_d.tv.min = s_q.tv.min + 7'h01;
                end
            end
            else
            begin
                s_d.tv.sec = s_q.tv.sec + 7'h01;
            end
        end

        // software write to the time value register wins over the ripple
        if (wr_time && s_q.unlock) // R1
        begin
            s_d.tv.sec  = time_new[`RCW_SEC_LSB +: 7];
            s_d.tv.min  = time_new[`RCW_MIN_LSB +: 7];
            s_d.tv.hour = time_new[`RCW_HOUR_LSB +: 5];
        end
        if (sec_wr)
        begin
            s_d.half  = 1'b0; // R7
            s_d.presc = 32'h0000_0000;
        end

        // control register write
        if (wr_ctrl)
        begin
            if (req.byteenable[1] && s_q.unlock) // R3
            begin
                s_d.on = req.writedata[`RCW_BIT_ON];
            end
            if (req.byteenable[0])
            begin
                // R2 R11
                s_d.unlock = req.writedata[`RCW_BIT_UNLOCK] & (s_q.unlock | wr_seq_active_i);
                s_d.oe     = req.writedata[`RCW_BIT_OE];
            end
        end

        // hazard covers the cycles before a seconds ripple
        s_d.hazard = s_q.on & s_q.half & (s_q.presc >= HAZ_START); // R4

        // clock output pin
        s_d.clk_out  = s_q.on & s_q.half;
        s_d.clk_oe_n = ~(s_q.oe & s_q.on); // R8

        // non-power-on reset: bus and timebase only, control kept
        if (soft_rst_i) // R9
        begin
            s_d.waitreq = 1'b1;
            s_d.presc   = 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            s_q          <= '0;
            s_q.waitreq  <= 1'b1;
            s_q.clk_oe_n <= 1'b1;
        end
        else if (ce_i)
        begin
            s_q <= s_d;
        end
    end

    assign avs_readdata_o    = s_q.rdata;
    assign avs_waitrequest_o = s_q.waitreq;
    assign rtc_clk_out_o     = s_q.clk_out;
    assign rtc_clk_oe_n_o    = s_q.clk_oe_n;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    locked_time_hold_a: assert property ( // R1
        (ce_i && wr_time && !s_q.unlock && !sec_tick) |=> s_q.tv == $past(s_q.tv))
        else $error("time value changed while locked");

    unlock_needs_seq_a: assert property ( // R2
        $rose(s_q.unlock) |-> $past(wr_seq_active_i) && $past(wr_ctrl))
        else $error("unlock set without active sequence");

    enable_when_unlocked_a: assert property ( // R3
        (s_q.on != $past(s_q.on)) |-> $past(s_q.unlock) && $past(wr_ctrl))
        else $error("enable changed while locked");

    hazard_before_ripple_a: assert property ( // R4
        (ce_i && s_q.on && s_q.half && s_q.presc >= HAZ_START) |=> s_q.hazard)
        else $error("hazard missing before rollover");

    half_flag_toggle_a: assert property ( // R6
        (ce_i && half_tick && !sec_wr) |=> s_q.half != $past(s_q.half))
        else $error("half flag did not toggle");

    sec_write_clear_a: assert property ( // R7
        (ce_i && sec_wr) |=> !s_q.half ##1 (s_q.half == 1'b0 || !s_q.on))
        else $error("seconds write did not clear half flag");

    clk_pin_enable_a: assert property ( // R8
        ($past(ce_i) && !$past(soft_rst_i))
            |-> rtc_clk_oe_n_o == !($past(s_q.oe) && $past(s_q.on)))
        else $error("clock pin enable wrong");

    soft_reset_keep_a: assert property ( // R9
        (ce_i && soft_rst_i && !wr_ctrl)
            |=> s_q.unlock == $past(s_q.unlock) && s_q.oe == $past(s_q.oe))
        else $error("soft reset touched control");

    bus_answer_a: assert property (
        (ce_i && bus_req && s_q.waitreq && !soft_rst_i) |=> !avs_waitrequest_o)
        else $error("bus answer late");

endmodule

`default_nettype wire

// ### rcw_params.svh
// Contract
// R1 - value-write-unlock set lets time writes land; clear blocks them, contents kept
// R2 - value-write-unlock can only be set while the unlock sequence is active
// R3 - module enable bit is writable only while value-write-unlock is 1
// R4 - rollover-read-hazard reads 1 when a ripple may hit a read, else 0
// R5 - software reads twice while hazard is 1 and trusts only matching data
// R6 - read-only half-second flag is 1 in second half of each second
// R7 - any write to the seconds field clears the half-second flag
// R8 - clock-output-enable 1 drives the clock output onto its pin, 0 disables it; the code drives the pin only while module enable is also 1
// R9 - control register returns to reset values only on power-on reset
// R10 - at 1:1 divisor software skips one access after clearing enable
// R11 - unlock sequence active arrives as one level input from unlock logic
`ifndef RCW_PARAMS_SVH
`define RCW_PARAMS_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define RCW_OFS_CONTROL   4'h0
`define RCW_OFS_TIME      4'h4

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define RCW_BIT_ON        15
`define RCW_BIT_UNLOCK    3
`define RCW_BIT_HAZARD    2
`define RCW_BIT_HALF      1
`define RCW_BIT_OE        0
`define RCW_CONTROL_RST   32'h0000_0000

// ----------------------------------------------------------------
// time value register fields
// ----------------------------------------------------------------
`define RCW_SEC_LSB       8
`define RCW_MIN_LSB       16
`define RCW_HOUR_LSB      24
`define RCW_TIME_MASK     32'h1F7F_7F00
`define RCW_TIME_RST      32'h0000_0000
`define RCW_SEC_MAX       7'h3B
`define RCW_MIN_MAX       7'h3B
`define RCW_HOUR_MAX      5'h17

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RCW_CLK_PERIOD_NS 50
`define RCW_HALF_SEC_NS   500000000
`define RCW_HAZARD_CYC    32

`endif

// ### rcw_pkg.sv
package rcw_pkg;

    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } rcw_bus_req_t;

    typedef struct packed {
        logic [4:0] hour;
        logic [6:0] min;
        logic [6:0] sec;
    } rcw_time_t;

    typedef struct packed {
        logic        waitreq;
        logic [31:0] rdata;
        logic        on;
        logic        unlock;
        logic        hazard;
        logic        half;
        logic        oe;
        rcw_time_t   tv;
        logic [31:0] presc;
        logic        clk_out;
        logic        clk_oe_n;
    } rcw_state_t;

endpackage

// ### rtc_control_write_lock_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_control_write_lock_status_bench;
    // ----------------------------------------------------------------
    // stimulus and model state
    // ----------------------------------------------------------------
    logic        mclk_i     = 1'b0;
    logic        sys_rst_i  = 1'b1;
    logic        soft_rst_i = 1'b0;
    logic        wr_seq     = 1'b0;
    logic [3:0]  adr        = 4'h0;
    logic        rd         = 1'b0;
    logic        wr         = 1'b0;
    logic [31:0] wdat       = 32'h0000_0000;
    logic [31:0] rdat;
    logic        wait_o;
    logic        clk_o;
    logic        oe_n_o;
    logic [31:0] q;
    logic [31:0] tm;
    logic [31:0] tm2;
    int          num_errors = 0;
    int          compares   = 0;
    int          cyc        = 0;
    int          sec;

    // short half second so a full second fits in a few hundred cycles
    rcw_ctrl #(
        .HALF_SEC_CYC (64),
        .HAZARD_CYC   (4)
    ) dut (
        .mclk_i            (mclk_i),
        .sys_rst_i         (sys_rst_i),
        .soft_rst_i        (soft_rst_i),
        .ce_i              (1'b1),
        .wr_seq_active_i   (wr_seq),
        .avs_address_i     (adr),
        .avs_read_i        (rd),
        .avs_write_i       (wr),
        .avs_writedata_i   (wdat),
        .avs_byteenable_i  (4'hF),
        .avs_readdata_o    (rdat),
        .avs_waitrequest_o (wait_o),
        .rtc_clk_out_o     (clk_o),
        .rtc_clk_oe_n_o    (oe_n_o)
    );

    initial
    begin
        forever #25 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            num_errors = num_errors + 1;
            final_report();
        end
    end

    // ----------------------------------------------------------------
    // checks and bus cycles
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_pin(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected %s expected %b seen %b", nm, e, g);
        end
    endtask

    // request held until waitrequest is sampled low; data taken at that edge
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        // every access leaves an idle edge behind it, so none follows an enable clear at once
        @(posedge mclk_i);
        adr  <= a;
        rd   <= ~w;
        wr   <= w;
        wdat <= d;
        @(posedge mclk_i);
        while (wait_o !== 1'b0 && n < 16)
        begin
            @(posedge mclk_i);
            n++;
        end
        q = rdat;
        if (n >= 16)
        begin
            num_errors++;
            $display("unexpected waitrequest expected 0 seen 1");
        end
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string nm);
        bus(a, 1'b0, 32'h0000_0000);
        chk(nm, e, q);
    endtask

    task final_report;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h02F4));
        repeat (16) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        rdc(4'h0, 32'h0000_0000, "control");
        rdc(4'h4, 32'h0000_0000, "time");
        rdc(4'h8, 32'h0000_0000, "unmapped");
        // locked, no unlock sequence: only the output enable lands
        bus(4'h0, 1'b1, 32'hFFFF_FFFF);
        rdc(4'h0, 32'h0000_0001, "control");
        chk_pin("clk_oe_n", 1'b1, oe_n_o);
        sec = $urandom_range(57, 0);
        tm = {3'h0, 5'($urandom_range(23, 0)), 1'b0, 7'($urandom_range(59, 0)),
              1'b0, 7'(sec), 8'h00};
        bus(4'h4, 1'b1, tm);
        rdc(4'h4, 32'h0000_0000, "time");
        wr_seq <= 1'b1;
        bus(4'h0, 1'b1, 32'h0000_0009);
        wr_seq <= 1'b0;
        bus(4'h0, 1'b1, 32'h0000_8009);
        rdc(4'h0, 32'h0000_8009, "control");
        chk_pin("clk_oe_n", 1'b0, oe_n_o);
        bus(4'h4, 1'b1, tm);
        rdc(4'h4, tm, "time");
        rdc(4'h0, 32'h0000_8009, "control");
        repeat (76) @(posedge mclk_i);
        rdc(4'h0, 32'h0000_800B, "control");
        chk_pin("clk_out", 1'b1, clk_o);
        // poll every three cycles; the hazard window is wider than that
        for (int i = 0; i < 40 && q[2] !== 1'b1; i++)
            bus(4'h0, 1'b0, 32'h0000_0000);
        chk("control", 32'h0000_800F, q);
        // ripple may land between reads: only two equal reads are trusted
        do
        begin
            bus(4'h4, 1'b0, 32'h0000_0000);
            tm2 = q;
            bus(4'h4, 1'b0, 32'h0000_0000);
        end
        while (q !== tm2);
        chk("time", {tm[31:15], 7'(sec + 1), 8'h00}, q);
        repeat (20) @(posedge mclk_i);
        tm[14:8] = 7'(sec + 1);
        rdc(4'h4, tm, "time");
        // relock, then both gated writes must bounce
        bus(4'h0, 1'b1, 32'h0000_8001);
        bus(4'h4, 1'b1, 32'h0000_0000);
        bus(4'h0, 1'b1, 32'h0000_0001);
        rdc(4'h4, tm, "time");
        rdc(4'h0, 32'h0000_8001, "control");
        @(posedge mclk_i);
        soft_rst_i <= 1'b1;
        @(posedge mclk_i);
        soft_rst_i <= 1'b0;
        rdc(4'h0, 32'h0000_8001, "control");
        rdc(4'h4, tm, "time");
        sys_rst_i <= 1'b1;
        @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        rdc(4'h0, 32'h0000_0000, "control");
        chk_pin("clk_oe_n", 1'b1, oe_n_o);
        final_report();
    end
endmodule
`default_nettype wire
